// [aasc_top.sv]
`timescale 1ns/1ps
module aasc_top (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_analog_en,
	input wire logic [2:0] i_pll_mode_field,
	input wire logic i_sar_cmp,
	input wire logic i_half_cmp,
	input wire logic i_thresh_cmp,
	input wire logic i_reg_overload,
	output logic o_analog_en,
	output logic o_pll_reg_en,
	output logic o_adc_sample,
	output logic o_adc_convert,
	output logic [9:0] o_dac_code,
	output logic o_chan_port1,
	output logic [2:0] o_chan_pin,
	output logic [3:0] o_ref_sel,
	output logic o_buf_en,
	output logic o_threshold_irq,
	output logic o_half_supply_irq
);

	typedef enum logic [1:0] {AASC_IDLE, AASC_START, AASC_SAMPLE, AASC_APPROX} aasc_state_t;

	aasc_state_t state_r;
	aasc_pkg::aasc_ctrl_t ctrl_r;
	aasc_pkg::aasc_cmp_t cmp_meta_r;
	aasc_pkg::aasc_cmp_t cmp_sync_r;
	logic [5:0] conv_div_r;
	logic [5:0] io_div_r;
	logic conv_en;
	logic io_en;
	logic ack_r;
	logic [31:0] readdata_r;
	logic [7:0] rd_mux;
	logic wr_fire;
	logic wr_ctrl;
	logic [8:0] cyc_r;
	logic [3:0] bit_r;
	logic phase_r;
	logic [9:0] trial_r;
	logic [9:0] result_r;
	logic done_r;
	logic buf_r;
	logic irq_en_r;
	logic fault_r;
	logic thr_tog_r;
	logic half_tog_r;
	logic pll_en_r;
	logic sample_end;
	logic approx_end;

	// Slow-rate enables; one clock only, so f0 and the I/O rate are pulses
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || conv_en) begin
			conv_div_r <= 6'h00;
		end else begin
			conv_div_r <= conv_div_r + 6'h01;
		end
	end
	assign conv_en = (conv_div_r == aasc_pkg::CONV_DIV_LAST);

	always_ff @(posedge i_clk_sys) begin
		if (i_reset || io_en) begin
			io_div_r <= 6'h00;
		end else begin
			io_div_r <= io_div_r + 6'h01;
		end
	end
	assign io_en = (io_div_r == aasc_pkg::IO_DIV_LAST);

	// Analog comparators are asynchronous to us; only the second stage is read
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			cmp_meta_r <= '0;
			cmp_sync_r <= '0;
		end else begin
			cmp_meta_r <= '{i_sar_cmp, i_half_cmp, i_thresh_cmp, i_reg_overload};
			cmp_sync_r <= cmp_meta_r;
		end
	end

	// Bus slave: one wait cycle, then the access completes
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (i_avs_read || i_avs_write) && !ack_r;
		end
	end
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
	assign wr_fire = i_avs_write && ack_r && i_avs_byteenable[0];
	assign wr_ctrl = wr_fire && (i_avs_address == aasc_pkg::ADDR_CTRL_LOW);

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (i_avs_address)
			aasc_pkg::ADDR_CTRL_LOW: begin
				rd_mux[aasc_pkg::CTL_EOC_BIT] = done_r;
				rd_mux[1:0] = result_r[1:0];
			end
			aasc_pkg::ADDR_RES_HIGH: rd_mux = result_r[9:2];
			aasc_pkg::ADDR_ANA_STAT: begin
				rd_mux[aasc_pkg::ANA_IRQ_EN_BIT] = irq_en_r;
				rd_mux[aasc_pkg::ANA_HALF_BIT] = cmp_sync_r.half && o_analog_en;
				rd_mux[aasc_pkg::ANA_THR_BIT] = cmp_sync_r.thresh && o_analog_en;
				rd_mux[aasc_pkg::ANA_FAULT_BIT] = fault_r;
			end
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data captured in the wait cycle, stands through the answer cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			readdata_r <= 32'h0000_0000;
		end else if (i_avs_read && !ack_r) begin
			readdata_r <= {24'h00_0000, rd_mux};
		end
	end
	assign o_avs_readdata = readdata_r;

	// Conversion setup latched from the write that starts it
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ctrl_r <= aasc_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= i_avs_writedata[7:0];
		end
	end

	// Buffer enable bit; software owns its settling time
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			buf_r <= aasc_pkg::BUF_RST;
		end else if (wr_fire && i_avs_address == aasc_pkg::ADDR_RES_HIGH) begin
			buf_r <= i_avs_writedata[aasc_pkg::RESH_BUF_BIT];
		end
	end

	assign sample_end = conv_en && (cyc_r == aasc_pkg::aasc_sample_cyc(ctrl_r.sample_time_sel) - 9'h001);
	assign approx_end = conv_en && phase_r && (bit_r == 4'h0);

	// Sequencer; a new write restarts, power-down aborts
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || !o_analog_en) begin
			state_r <= AASC_IDLE;
			cyc_r <= 9'h000;
			bit_r <= aasc_pkg::TOP_BIT;
			phase_r <= 1'b0;
		end else if (wr_ctrl) begin
			state_r <= AASC_START;
			cyc_r <= 9'h000;
			bit_r <= aasc_pkg::TOP_BIT;
			phase_r <= 1'b0;
		end else begin
			unique case (state_r)
				AASC_IDLE: state_r <= AASC_IDLE;
				AASC_START: begin
					if (conv_en) begin
						state_r <= AASC_SAMPLE;
					end
				end
				AASC_SAMPLE: begin
					if (sample_end) begin
						state_r <= AASC_APPROX;
					end else if (conv_en) begin
						cyc_r <= cyc_r + 9'h001;
					end
				end
				AASC_APPROX: begin
					// Two f0 cycles per bit gives the fixed approximation length
					if (approx_end) begin
						state_r <= AASC_IDLE;
					end else if (conv_en) begin
						phase_r <= !phase_r;
						if (phase_r) begin
							bit_r <= bit_r - 4'h1;
						end
					end
				end
			endcase
		end
	end

	// Binary search code; comparator high means input at or above the trial
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || wr_ctrl) begin
			trial_r <= aasc_pkg::RESULT_RST;
		end else if (state_r == AASC_APPROX && conv_en) begin
			if (!phase_r) begin
				trial_r[bit_r] <= 1'b1;
			end else if (!cmp_sync_r.sar) begin
				trial_r[bit_r] <= 1'b0;
			end
		end
	end

	// Result only moves at the end of a conversion, so the old one stays
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			result_r <= aasc_pkg::RESULT_RST;
		end else if (state_r == AASC_APPROX && approx_end && !wr_ctrl) begin
			result_r <= cmp_sync_r.sar ? trial_r : {trial_r[9:1], 1'b0};
		end
	end

	// Done: ready when idle and powered, cleared by any control write with byte lane 0 enabled
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || !o_analog_en) begin
			done_r <= 1'b0;
		end else if (wr_ctrl) begin
			done_r <= 1'b0;
		end else if (state_r == AASC_IDLE) begin
			done_r <= 1'b1;
		end
	end

	// Half-supply interrupt enable
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			irq_en_r <= aasc_pkg::IRQ_EN_RST;
		end else if (wr_fire && i_avs_address == aasc_pkg::ADDR_ANA_STAT) begin
			irq_en_r <= i_avs_writedata[aasc_pkg::ANA_IRQ_EN_BIT];
		end
	end

	// Sticky regulator fault; a new overload beats a clear in the same cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			fault_r <= aasc_pkg::FAULT_RST;
		end else if (cmp_sync_r.overload && pll_en_r) begin
			fault_r <= 1'b1;
		end else if (wr_fire && i_avs_address == aasc_pkg::ADDR_ANA_STAT
			&& i_avs_writedata[aasc_pkg::ANA_FAULT_BIT]) begin
			fault_r <= 1'b0;
		end
	end

	// Interrupt sources toggle at the I/O rate so the controller sees repeats
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			thr_tog_r <= 1'b0;
			half_tog_r <= 1'b0;
		end else begin
			if (!(cmp_sync_r.thresh && o_analog_en)) begin
				thr_tog_r <= 1'b0;
			end else if (io_en) begin
				thr_tog_r <= !thr_tog_r;
			end
			if (!(cmp_sync_r.half && o_analog_en && irq_en_r)) begin
				half_tog_r <= 1'b0;
			end else if (io_en) begin
				half_tog_r <= !half_tog_r;
			end
		end
	end
	assign o_threshold_irq = thr_tog_r;
	assign o_half_supply_irq = half_tog_r;

	// PLL supply regulator follows the PLL mode
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pll_en_r <= 1'b0;
		end else begin
			pll_en_r <= (i_pll_mode_field != 3'h0);
		end
	end
	assign o_pll_reg_en = pll_en_r;

	// One enable powers converter and both comparators
	assign o_analog_en = i_analog_en && !i_reset;

	// Analog front-end controls
	assign o_adc_sample = (state_r == AASC_SAMPLE);
	assign o_adc_convert = (state_r == AASC_APPROX);
	assign o_dac_code = trial_r;
	assign o_chan_port1 = ctrl_r.channel[3];
	assign o_chan_pin = ctrl_r.channel[2:0];
	assign o_buf_en = buf_r;
	always_comb begin
		o_ref_sel = 4'h0;
		o_ref_sel[ctrl_r.ref_sel] = 1'b1;
	end

	// Helper: f0 cycles spent in sampling
	logic [8:0] samp_seen_r;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || !o_adc_sample) begin
			samp_seen_r <= 9'h000;
		end else if (conv_en) begin
			samp_seen_r <= samp_seen_r + 9'h001;
		end
	end

	sequence s_ctrl_write;
		wr_ctrl && o_analog_en;
	endsequence

	// Next f0 enable is at most four system cycles away
	sequence s_sample_begins;
		(state_r == AASC_START) ##[1:4] o_adc_sample;
	endsequence

	a_start_after_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_ctrl_write |=> s_sample_begins)
		else $error("sampling did not begin one f0 cycle after write");

	a_eoc_clears: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_ctrl_write |=> !done_r ##1 !done_r)
		else $error("done flag not cleared by control write");

	a_sample_length: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		$fell(o_adc_sample) && o_adc_convert
		|-> samp_seen_r == aasc_pkg::aasc_sample_cyc(ctrl_r.sample_time_sel)
		&& $past(samp_seen_r) + 9'h001 == samp_seen_r)
		else $error("sampling length does not match select");

	a_result_split: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		ack_r && i_avs_read && $stable(result_r) && i_avs_address == aasc_pkg::ADDR_RES_HIGH
		|-> o_avs_readdata[7:0] == result_r[9:2])
		else $error("high result register shows wrong bits");

	a_result_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!(o_adc_convert && approx_end) |=> $stable(result_r))
		else $error("result changed outside conversion end");

	a_ref_onehot: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_adc_convert |-> $onehot(o_ref_sel) && o_ref_sel[ctrl_r.ref_sel])
		else $error("reference select not decoded");

	a_fault_sticky: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		cmp_sync_r.overload && pll_en_r |=> fault_r)
		else $error("regulator fault not captured");

	a_half_irq_gate: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!irq_en_r |=> !o_half_supply_irq)
		else $error("half-supply source passed while disabled");

	a_thr_toggles: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		cmp_sync_r.thresh && o_analog_en && io_en ##1 cmp_sync_r.thresh && o_analog_en
		|-> o_threshold_irq != $past(o_threshold_irq))
		else $error("threshold source did not toggle");

	a_pll_reg_follow: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(i_pll_mode_field != 3'h0) |=> o_pll_reg_en)
		else $error("PLL regulator not enabled");

	a_off_no_conv: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!o_analog_en |=> !o_adc_sample && !o_adc_convert && !done_r)
		else $error("converter active while powered off");

endmodule // aasc_top

// [aasc_pkg.sv]
package aasc_pkg;

	// System clock and the derived slower rates (one-cycle enables)
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int CONV_CLK_HZ = 10_000_000;
	localparam int IO_CLK_HZ = 1_000_000;
	localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
	localparam int IO_DIV = SYS_CLK_HZ / IO_CLK_HZ;
	localparam logic [5:0] CONV_DIV_LAST = 6'(CONV_DIV - 1);
	localparam logic [5:0] IO_DIV_LAST = 6'(IO_DIV - 1);

	// Register byte addresses on the bus
	localparam logic [4:0] ADDR_CTRL_LOW = 5'h00;
	localparam logic [4:0] ADDR_RES_HIGH = 5'h04;
	localparam logic [4:0] ADDR_ANA_STAT = 5'h08;

	// Field positions
	localparam int CTL_EOC_BIT = 7;
	localparam int CTL_SAMPLE_TIME_SEL_LSB = 6;
	localparam int CTL_REF_LSB = 4;
	localparam int CTL_CHAN_LSB = 0;
	localparam int RESH_BUF_BIT = 0;
	localparam int ANA_IRQ_EN_BIT = 7;
	localparam int ANA_HALF_BIT = 6;
	localparam int ANA_THR_BIT = 5;
	localparam int ANA_FAULT_BIT = 0;

	// Values after reset
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [9:0] RESULT_RST = 10'h000;
	localparam logic BUF_RST = 1'b0;
	localparam logic IRQ_EN_RST = 1'b0;
	localparam logic FAULT_RST = 1'b0;

	// Sample and total conversion lengths in conversion-clock cycles
	localparam logic [8:0] SAMPLE_CYC_0 = 9'h014;
	localparam logic [8:0] SAMPLE_CYC_1 = 9'h03C;
	localparam logic [8:0] SAMPLE_CYC_2 = 9'h08C;
	localparam logic [8:0] SAMPLE_CYC_3 = 9'h12C;
	localparam logic [8:0] TOTAL_CYC_0 = 9'h028;
	localparam logic [8:0] TOTAL_CYC_1 = 9'h050;
	localparam logic [8:0] TOTAL_CYC_2 = 9'h0A0;
	localparam logic [8:0] TOTAL_CYC_3 = 9'h140;
	localparam logic [8:0] APPROX_CYC = TOTAL_CYC_0 - SAMPLE_CYC_0;
	localparam int RESULT_W = 10;
	localparam logic [3:0] TOP_BIT = 4'h9;

	// Reference select codes
	localparam logic [1:0] REF_EXT_A = 2'h0;
	localparam logic [1:0] REF_INT = 2'h1;
	localparam logic [1:0] REF_EXT_B = 2'h2;
	localparam logic [1:0] REF_EXT_C = 2'h3;

	typedef struct packed {
		logic [1:0] sample_time_sel;
		logic [1:0] ref_sel;
		logic [3:0] channel;
	} aasc_ctrl_t;

	typedef struct packed {
		logic sar;
		logic half;
		logic thresh;
		logic overload;
	} aasc_cmp_t;

	// Sampling length for a sample-time select value
	function automatic logic [8:0] aasc_sample_cyc(input logic [1:0] sel);
		unique case (sel)
			2'h0: aasc_sample_cyc = SAMPLE_CYC_0;
			2'h1: aasc_sample_cyc = SAMPLE_CYC_1;
			2'h2: aasc_sample_cyc = SAMPLE_CYC_2;
			2'h3: aasc_sample_cyc = SAMPLE_CYC_3;
		endcase
	endfunction

endpackage

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic i_clk_sys, i_reset, i_avs_read, i_avs_write, i_analog_en, i_half_cmp;
	logic i_thresh_cmp, i_reg_overload, o_avs_waitrequest, o_analog_en, o_pll_reg_en;
	logic o_adc_sample, o_adc_convert, o_chan_port1, o_buf_en, o_threshold_irq, o_half_supply_irq;
	logic i_sar_cmp = 1'b0;
	logic chk_en = 1'b0;
	logic [4:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata;
	logic [3:0] i_avs_byteenable, o_ref_sel;
	logic [2:0] i_pll_mode_field, o_chan_pin;
	logic [9:0] o_dac_code, vin, prev;
	logic [63:0] exp_q[$];
	int n_errors = 0;
	int tests_run = 0;
	int n_samp = 0;
	int n_conv = 0;
	int seed = 79025;
	int samp_tab[4] = '{20, 60, 140, 300};

	aasc_top u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_analog_en(i_analog_en),
		.i_pll_mode_field(i_pll_mode_field), .i_sar_cmp(i_sar_cmp), .i_half_cmp(i_half_cmp),
		.i_thresh_cmp(i_thresh_cmp), .i_reg_overload(i_reg_overload), .o_analog_en(o_analog_en),
		.o_pll_reg_en(o_pll_reg_en), .o_adc_sample(o_adc_sample), .o_adc_convert(o_adc_convert),
		.o_dac_code(o_dac_code), .o_chan_port1(o_chan_port1), .o_chan_pin(o_chan_pin),
		.o_ref_sel(o_ref_sel), .o_buf_en(o_buf_en), .o_threshold_irq(o_threshold_irq),
		.o_half_supply_irq(o_half_supply_irq));

	// 40 MHz system clock
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	// Ideal SAR comparator: keeps a trial bit while the input is not below it
	always @(posedge i_clk_sys) begin
		i_sar_cmp <= (vin >= o_dac_code);
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %0h, seen %0h", nm, e, g);
		end
	endtask

	// Phase counters, and read data checked against the oldest note
	always @(posedge i_clk_sys) begin
		logic [63:0] note;
		if (o_adc_sample === 1'b1) n_samp++;
		if ((o_adc_sample | o_adc_convert) === 1'b1) n_conv++;
		if (i_avs_read && chk_en && o_avs_waitrequest === 1'b0) begin
			note = exp_q.pop_front();
			chk("readdata", note[31:0], o_avs_readdata & note[63:32]);
		end
	end

	// Holds the request until waitrequest is seen low; the guard only stops a hang
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be, input logic ck, output logic [31:0] q);
		@(posedge i_clk_sys);
		i_avs_read <= ~w;
		i_avs_write <= w;
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		chk_en <= ck;
		// Only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge i_clk_sys);
		end while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		chk_en <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		exp_q.push_back({m, e & m});
		bus(1'b0, a, 32'h0, 4'h0, 1'b1, q);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		bus(1'b1, a, d, be, 1'b0, q);
		// Let the register settle before anyone looks at it
		@(posedge i_clk_sys);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask

	// One conversion, with the previous result still readable while busy
	task automatic conv(input logic [1:0] ts, input logic [1:0] rf, input logic [9:0] v);
		logic [3:0] ch;
		logic [31:0] q;
		int s0, c0;
		ch = 4'($random(seed));
		vin <= v;
		s0 = n_samp;
		c0 = n_conv;
		wr(aasc_pkg::ADDR_CTRL_LOW, {24'h0, ts, rf, ch}, 4'hF);
		wait_cyc(1);
		chk("chan_port1", {31'h0, ch[3]}, {31'h0, o_chan_port1});
		chk("chan_pin", {29'h0, ch[2:0]}, {29'h0, o_chan_pin});
		chk("ref_sel", 32'h1 << rf, {28'h0, o_ref_sel});
		rd(aasc_pkg::ADDR_RES_HIGH, 32'hFF, {24'h0, prev[9:2]});
		rd(aasc_pkg::ADDR_CTRL_LOW, 32'h83, {30'h0, prev[1:0]});
		do begin
			bus(1'b0, aasc_pkg::ADDR_CTRL_LOW, 32'h0, 4'h0, 1'b0, q);
		end while (q[7] !== 1'b1);
		chk("sample_cycles", samp_tab[ts] * aasc_pkg::CONV_DIV, n_samp - s0);
		chk("conv_cycles", (samp_tab[ts] + 20) * aasc_pkg::CONV_DIV, n_conv - c0);
		rd(aasc_pkg::ADDR_RES_HIGH, 32'hFF, {24'h0, v[9:2]});
		rd(aasc_pkg::ADDR_CTRL_LOW, 32'h83, {24'h0, 6'h20, v[1:0]});
		prev = v;
	endtask

	task automatic end_sim;
		$display("errors %0d, comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Watchdog sized well above the longest conversion sequence
	initial begin
		wait_cyc(40000);
		n_errors++;
		end_sim();
	end

	// Main sequence
	initial begin
		logic t;
		i_reset = 1'b1;
		{i_avs_read, i_avs_write, i_analog_en, i_half_cmp, i_thresh_cmp, i_reg_overload} = 6'h00;
		i_avs_address = 5'h00;
		i_avs_writedata = 32'h0;
		i_avs_byteenable = 4'h0;
		i_pll_mode_field = 3'h0;
		vin = 10'h000;
		prev = 10'h000;
		wait_cyc(4);
		i_reset <= 1'b0;
		rd(aasc_pkg::ADDR_CTRL_LOW, 32'hFFFFFFFF, 32'h0);
		rd(aasc_pkg::ADDR_RES_HIGH, 32'hFFFFFFFF, 32'h0);
		rd(aasc_pkg::ADDR_ANA_STAT, 32'hFFFFFFFF, 32'h0);
		chk("analog_en", 32'h0, {31'h0, o_analog_en});
		// Buffer bit: a write without byte lane 0 must be ignored
		wr(aasc_pkg::ADDR_RES_HIGH, 32'h1, 4'h0);
		chk("buf_en", 32'h0, {31'h0, o_buf_en});
		wr(aasc_pkg::ADDR_RES_HIGH, 32'h1, 4'h1);
		chk("buf_en", 32'h1, {31'h0, o_buf_en});
		wr(5'h0C, 32'hFF, 4'hF);
		rd(5'h0C, 32'hFFFFFFFF, 32'h0);
		wait_cyc(40);
		i_analog_en <= 1'b1;
		wait_cyc(3);
		chk("analog_en", 32'h1, {31'h0, o_analog_en});
		rd(aasc_pkg::ADDR_CTRL_LOW, 32'h80, 32'h80);
		for (int i = 0; i < 6; i++) begin
			conv(2'(i), 2'(i + 1), (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($random(seed)));
		end
		// Threshold comparator: flag and a free-toggling source while high
		i_thresh_cmp <= 1'b1;
		wait_cyc(4);
		rd(aasc_pkg::ADDR_ANA_STAT, 32'h20, 32'h20);
		repeat (2) begin
			t = o_threshold_irq;
			wait_cyc(aasc_pkg::IO_DIV);
			chk("threshold_irq", {31'h0, ~t}, {31'h0, o_threshold_irq});
		end
		i_thresh_cmp <= 1'b0;
		wait_cyc(4);
		rd(aasc_pkg::ADDR_ANA_STAT, 32'h20, 32'h0);
		chk("threshold_irq", 32'h0, {31'h0, o_threshold_irq});
		// Half-supply comparator: source gated by its enable bit
		i_half_cmp <= 1'b1;
		wait_cyc(4);
		rd(aasc_pkg::ADDR_ANA_STAT, 32'hC0, 32'h40);
		repeat (2) begin
			wait_cyc(aasc_pkg::IO_DIV);
			chk("half_irq", 32'h0, {31'h0, o_half_supply_irq});
		end
		wr(aasc_pkg::ADDR_ANA_STAT, 32'h80, 4'h1);
		rd(aasc_pkg::ADDR_ANA_STAT, 32'hC0, 32'hC0);
		repeat (2) begin
			t = o_half_supply_irq;
			wait_cyc(aasc_pkg::IO_DIV);
			chk("half_irq", {31'h0, ~t}, {31'h0, o_half_supply_irq});
		end
		// Regulator fault is sticky: write 0 keeps it, write 1 clears it
		i_pll_mode_field <= 3'h5;
		wait_cyc(3);
		chk("pll_reg_en", 32'h1, {31'h0, o_pll_reg_en});
		i_reg_overload <= 1'b1;
		wait_cyc(2);
		i_reg_overload <= 1'b0;
		wait_cyc(4);
		rd(aasc_pkg::ADDR_ANA_STAT, 32'h01, 32'h01);
		wr(aasc_pkg::ADDR_ANA_STAT, 32'h80, 4'h1);
		rd(aasc_pkg::ADDR_ANA_STAT, 32'h81, 32'h81);
		wr(aasc_pkg::ADDR_ANA_STAT, 32'h81, 4'h1);
		rd(aasc_pkg::ADDR_ANA_STAT, 32'h01, 32'h00);
		i_pll_mode_field <= 3'h0;
		wait_cyc(3);
		chk("pll_reg_en", 32'h0, {31'h0, o_pll_reg_en});
		// Power off: flags and done read 0 although the half input stays high
		i_analog_en <= 1'b0;
		wait_cyc(4);
		chk("analog_en", 32'h0, {31'h0, o_analog_en});
		rd(aasc_pkg::ADDR_ANA_STAT, 32'h60, 32'h0);
		rd(aasc_pkg::ADDR_CTRL_LOW, 32'h80, 32'h0);
		wait_cyc(2);
		end_sim();
	end
endmodule // tb_top
